// >>> hw/ics_pkg.sv
// Constants and types of the instruction cycle sequencer
// Functional notes
// - Internal clock is crystal divided by four
// - Sync output marks the op-code fetch cycle
// - Op code latched in second half of sync cycle
// - Stop resumes only on external interrupt
// - Wait resumes on internal or external interrupt
// - Push accumulator/status: one byte, three cycles
// - Pull accumulator/status: one byte, four cycles
// - Accumulator bit branch: two bytes, four/six
// - Accumulator bit clear/set: one byte, two
// - Zero-page bit branch: three bytes, five/seven
// - Zero-page bit clear/set: two bytes, five
// - Load memory immediate: three bytes, four
// - Zero-page stores: two bytes, four cycles
// - Zero-page X read-modify-write: two bytes, six
// - Multiply zero-page X: two bytes, fifteen
// - Divide zero-page X: two bytes, sixteen
// - Indirect jump: three bytes, five cycles
// - Store accumulator indirect X: two, seven
// - Store accumulator absolute X/Y: three, six
// - T=1 immediate arithmetic takes five cycles
// - T=1 absolute arithmetic: three bytes, seven
// - T=1 indirect Y arithmetic: two, nine
package ics_pkg;

	localparam int DIV_RATIO = 4;
	localparam logic [1:0] PHASE_LAST = 2'(DIV_RATIO - 1);
	localparam logic [1:0] PHASE_HALF = 2'(DIV_RATIO / 2 - 1);

	localparam logic [4:0] CYC_FIRST     = 5'h01;
	localparam logic [4:0] CYC_IMPLIED   = 5'h02;
	localparam logic [4:0] CYC_BREAK     = 5'h07;
	localparam logic [4:0] CYC_HALT      = 5'h02;
	localparam logic [4:0] CYC_PUSH      = 5'h03;
	localparam logic [4:0] CYC_PULL      = 5'h04;
	localparam logic [4:0] CYC_BRA_A     = 5'h04;
	localparam logic [4:0] CYC_BRA_A_TK  = 5'h06;
	localparam logic [4:0] CYC_BIT_A     = 5'h02;
	localparam logic [4:0] CYC_BRA_ZP    = 5'h05;
	localparam logic [4:0] CYC_BRA_ZP_TK = 5'h07;
	localparam logic [4:0] CYC_BIT_ZP    = 5'h05;
	localparam logic [4:0] CYC_LDM       = 5'h04;
	localparam logic [4:0] CYC_ST_ZP     = 5'h04;
	localparam logic [4:0] CYC_RMW_ZPX   = 5'h06;
	localparam logic [4:0] CYC_MUL       = 5'h0F;
	localparam logic [4:0] CYC_DIV       = 5'h10;
	localparam logic [4:0] CYC_JMP_IND   = 5'h05;
	localparam logic [4:0] CYC_STA_INDX  = 5'h07;
	localparam logic [4:0] CYC_STA_ABSXY = 5'h06;
	localparam logic [4:0] CYC_ALU_IMM   = 5'h02;
	localparam logic [4:0] CYC_ALU_IMM_T = 5'h05;
	localparam logic [4:0] CYC_ALU_ZP    = 5'h03;
	localparam logic [4:0] CYC_ALU_ZP_T  = 5'h06;
	localparam logic [4:0] CYC_ALU_ZPX   = 5'h04;
	localparam logic [4:0] CYC_ALU_ZPX_T = 5'h07;
	localparam logic [4:0] CYC_ALU_ABS   = 5'h04;
	localparam logic [4:0] CYC_ALU_ABS_T = 5'h07;
	localparam logic [4:0] CYC_ALU_AXY   = 5'h05;
	localparam logic [4:0] CYC_ALU_AXY_T = 5'h08;
	localparam logic [4:0] CYC_ALU_INX   = 5'h06;
	localparam logic [4:0] CYC_ALU_INX_T = 5'h09;
	localparam logic [4:0] CYC_ALU_INY   = 5'h06;
	localparam logic [4:0] CYC_ALU_INY_T = 5'h09;
	localparam logic [4:0] CYC_REL       = 5'h02;
	localparam logic [4:0] CYC_REL_TK    = 5'h04;
	localparam logic [4:0] CYC_RMW_ZP    = 5'h05;
	localparam logic [4:0] CYC_RRF       = 5'h08;
	localparam logic [4:0] CYC_JSR       = 5'h06;
	localparam logic [4:0] CYC_JMP_ABS   = 5'h03;

	localparam logic [1:0] LEN_ONE   = 2'h1;
	localparam logic [1:0] LEN_TWO   = 2'h2;
	localparam logic [1:0] LEN_THREE = 2'h3;

	typedef enum logic [4:0] {
		CLS_IMPLIED   = 5'b00000,
		CLS_BREAK     = 5'b00001,
		CLS_STOP      = 5'b00010,
		CLS_WAIT      = 5'b00011,
		CLS_PUSH      = 5'b00100,
		CLS_PULL      = 5'b00101,
		CLS_ACC       = 5'b00110,
		CLS_BIT_A     = 5'b00111,
		CLS_BRA_A     = 5'b01000,
		CLS_BRA_ZP    = 5'b01001,
		CLS_BIT_ZP    = 5'b01010,
		CLS_LDM       = 5'b01011,
		CLS_ST_ZP     = 5'b01100,
		CLS_RMW_ZPX   = 5'b01101,
		CLS_MUL       = 5'b01110,
		CLS_DIV       = 5'b01111,
		CLS_JMP_IND   = 5'b10000,
		CLS_STA_INDX  = 5'b10001,
		CLS_STA_ABSXY = 5'b10010,
		CLS_ALU_IMM   = 5'b10011,
		CLS_ALU_ZP    = 5'b10100,
		CLS_ALU_ZPX   = 5'b10101,
		CLS_ALU_ABS   = 5'b10110,
		CLS_ALU_AXY   = 5'b10111,
		CLS_ALU_INX   = 5'b11000,
		CLS_ALU_INY   = 5'b11001,
		CLS_REL       = 5'b11010,
		CLS_RMW_ZP    = 5'b11011,
		CLS_RRF       = 5'b11100,
		CLS_JSR       = 5'b11101,
		CLS_JMP_ABS   = 5'b11110
	} ics_class_t;

	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_EXEC  = 2'b01,
		ST_STOP  = 2'b10,
		ST_WAIT  = 2'b11
	} ics_state_t;

endpackage

// >>> hw/ics_phase_div.sv
// Crystal to internal clock phase divider
`timescale 1ns/1ps
module ics_phase_div
(
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	output logic      phi_o,
	output logic      half_o,
	output logic      end_o
);

	typedef struct packed {
		logic [1:0] phase;
		logic       phi;
	} ics_div_st_t;

	ics_div_st_t q;
	ics_div_st_t next_q;

	always_comb
	begin
		next_q = q;
		next_q.phase = q.phase + 2'h1;
		next_q.phi = (next_q.phase > ics_pkg::PHASE_HALF);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign phi_o  = q.phi;
	// Enables, one crystal period each
	assign half_o = (q.phase == ics_pkg::PHASE_HALF);
	assign end_o  = (q.phase == ics_pkg::PHASE_LAST);

endmodule

// >>> hw/ics_sequencer.sv
// Instruction cycle sequencer: fetch sync, op code latch, cycle counts
`timescale 1ns/1ps
module ics_sequencer
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  data_i,
	input  wire logic [4:0]  class_i,
	input  wire logic        t_flag_i,
	input  wire logic        branch_taken_i,
	input  wire logic        ext_irq_i,
	input  wire logic        int_irq_i,
	output logic             phi_o,
	output logic             phi_end_o,
	output logic             sync_o,
	output logic [7:0]       opcode_o,
	output logic [4:0]       cycle_o,
	output logic [1:0]       bytes_o,
	output logic             instr_done_o,
	output logic             stopped_o,
	output logic             waiting_o
);

	typedef struct packed {
		ics_pkg::ics_state_t st;
		logic [4:0]          cnt;
		logic [7:0]          opcode;
		logic                t_mode;
		logic [1:0]          bytes;
		logic                done;
		logic                ext_s1;
		logic                ext_s2;
		logic                ext_s3;
		logic                ext_level;
	} ics_seq_st_t;

	ics_seq_st_t q;
	ics_seq_st_t next_q;

	logic phi;
	logic phi_half;
	logic phi_end;

	ics_phase_div u_div
	(
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.phi_o     (phi),
		.half_o    (phi_half),
		.end_o     (phi_end)
	);

	// Cycles of the short form; branch not taken or T clear
	function automatic logic [4:0] base_cycles(input logic [4:0] cls);
		case (ics_pkg::ics_class_t'(cls))
			ics_pkg::CLS_IMPLIED:   base_cycles = ics_pkg::CYC_IMPLIED;
			ics_pkg::CLS_BREAK:     base_cycles = ics_pkg::CYC_BREAK;
			ics_pkg::CLS_STOP:      base_cycles = ics_pkg::CYC_HALT;
			ics_pkg::CLS_WAIT:      base_cycles = ics_pkg::CYC_HALT;
			ics_pkg::CLS_PUSH:      base_cycles = ics_pkg::CYC_PUSH;
			ics_pkg::CLS_PULL:      base_cycles = ics_pkg::CYC_PULL;
			ics_pkg::CLS_ACC:       base_cycles = ics_pkg::CYC_IMPLIED;
			ics_pkg::CLS_BIT_A:     base_cycles = ics_pkg::CYC_BIT_A;
			ics_pkg::CLS_BRA_A:     base_cycles = ics_pkg::CYC_BRA_A;
			ics_pkg::CLS_BRA_ZP:    base_cycles = ics_pkg::CYC_BRA_ZP;
			ics_pkg::CLS_BIT_ZP:    base_cycles = ics_pkg::CYC_BIT_ZP;
			ics_pkg::CLS_LDM:       base_cycles = ics_pkg::CYC_LDM;
			ics_pkg::CLS_ST_ZP:     base_cycles = ics_pkg::CYC_ST_ZP;
			ics_pkg::CLS_RMW_ZPX:   base_cycles = ics_pkg::CYC_RMW_ZPX;
			ics_pkg::CLS_MUL:       base_cycles = ics_pkg::CYC_MUL;
			ics_pkg::CLS_DIV:       base_cycles = ics_pkg::CYC_DIV;
			ics_pkg::CLS_JMP_IND:   base_cycles = ics_pkg::CYC_JMP_IND;
			ics_pkg::CLS_STA_INDX:  base_cycles = ics_pkg::CYC_STA_INDX;
			ics_pkg::CLS_STA_ABSXY: base_cycles = ics_pkg::CYC_STA_ABSXY;
			ics_pkg::CLS_ALU_IMM:   base_cycles = ics_pkg::CYC_ALU_IMM;
			ics_pkg::CLS_ALU_ZP:    base_cycles = ics_pkg::CYC_ALU_ZP;
			ics_pkg::CLS_ALU_ZPX:   base_cycles = ics_pkg::CYC_ALU_ZPX;
			ics_pkg::CLS_ALU_ABS:   base_cycles = ics_pkg::CYC_ALU_ABS;
			ics_pkg::CLS_ALU_AXY:   base_cycles = ics_pkg::CYC_ALU_AXY;
			ics_pkg::CLS_ALU_INX:   base_cycles = ics_pkg::CYC_ALU_INX;
			ics_pkg::CLS_ALU_INY:   base_cycles = ics_pkg::CYC_ALU_INY;
			ics_pkg::CLS_REL:       base_cycles = ics_pkg::CYC_REL;
			ics_pkg::CLS_RMW_ZP:    base_cycles = ics_pkg::CYC_RMW_ZP;
			ics_pkg::CLS_RRF:       base_cycles = ics_pkg::CYC_RRF;
			ics_pkg::CLS_JSR:       base_cycles = ics_pkg::CYC_JSR;
			ics_pkg::CLS_JMP_ABS:   base_cycles = ics_pkg::CYC_JMP_ABS;
			default:                base_cycles = ics_pkg::CYC_IMPLIED;
		endcase
	endfunction

	// Cycles of the long form; branch taken or T set
	function automatic logic [4:0] alt_cycles(input logic [4:0] cls);
		case (ics_pkg::ics_class_t'(cls))
			ics_pkg::CLS_BRA_A:   alt_cycles = ics_pkg::CYC_BRA_A_TK;
			ics_pkg::CLS_BRA_ZP:  alt_cycles = ics_pkg::CYC_BRA_ZP_TK;
			ics_pkg::CLS_REL:     alt_cycles = ics_pkg::CYC_REL_TK;
			ics_pkg::CLS_ALU_IMM: alt_cycles = ics_pkg::CYC_ALU_IMM_T;
			ics_pkg::CLS_ALU_ZP:  alt_cycles = ics_pkg::CYC_ALU_ZP_T;
			ics_pkg::CLS_ALU_ZPX: alt_cycles = ics_pkg::CYC_ALU_ZPX_T;
			ics_pkg::CLS_ALU_ABS: alt_cycles = ics_pkg::CYC_ALU_ABS_T;
			ics_pkg::CLS_ALU_AXY: alt_cycles = ics_pkg::CYC_ALU_AXY_T;
			ics_pkg::CLS_ALU_INX: alt_cycles = ics_pkg::CYC_ALU_INX_T;
			ics_pkg::CLS_ALU_INY: alt_cycles = ics_pkg::CYC_ALU_INY_T;
			default:              alt_cycles = base_cycles(cls);
		endcase
	endfunction

	function automatic logic is_branch(input logic [4:0] cls);
		case (ics_pkg::ics_class_t'(cls))
			ics_pkg::CLS_BRA_A:  is_branch = 1'b1;
			ics_pkg::CLS_BRA_ZP: is_branch = 1'b1;
			ics_pkg::CLS_REL:    is_branch = 1'b1;
			default:             is_branch = 1'b0;
		endcase
	endfunction

	// Only the arithmetic and logic group reacts to the T flag
	function automatic logic is_t_class(input logic [4:0] cls);
		case (ics_pkg::ics_class_t'(cls))
			ics_pkg::CLS_ALU_IMM: is_t_class = 1'b1;
			ics_pkg::CLS_ALU_ZP:  is_t_class = 1'b1;
			ics_pkg::CLS_ALU_ZPX: is_t_class = 1'b1;
			ics_pkg::CLS_ALU_ABS: is_t_class = 1'b1;
			ics_pkg::CLS_ALU_AXY: is_t_class = 1'b1;
			ics_pkg::CLS_ALU_INX: is_t_class = 1'b1;
			ics_pkg::CLS_ALU_INY: is_t_class = 1'b1;
			default:              is_t_class = 1'b0;
		endcase
	endfunction

	function automatic logic [1:0] byte_len(input logic [4:0] cls);
		case (ics_pkg::ics_class_t'(cls))
			ics_pkg::CLS_IMPLIED:   byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_BREAK:     byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_STOP:      byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_WAIT:      byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_PUSH:      byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_PULL:      byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_ACC:       byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_BIT_A:     byte_len = ics_pkg::LEN_ONE;
			ics_pkg::CLS_BRA_A:     byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_BRA_ZP:    byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_BIT_ZP:    byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_LDM:       byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_ST_ZP:     byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_RMW_ZPX:   byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_MUL:       byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_DIV:       byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_JMP_IND:   byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_STA_INDX:  byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_STA_ABSXY: byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_ALU_IMM:   byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_ALU_ZP:    byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_ALU_ZPX:   byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_ALU_ABS:   byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_ALU_AXY:   byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_ALU_INX:   byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_ALU_INY:   byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_REL:       byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_RMW_ZP:    byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_RRF:       byte_len = ics_pkg::LEN_TWO;
			ics_pkg::CLS_JSR:       byte_len = ics_pkg::LEN_THREE;
			ics_pkg::CLS_JMP_ABS:   byte_len = ics_pkg::LEN_THREE;
			default:                byte_len = ics_pkg::LEN_ONE;
		endcase
	endfunction

	// Length of the running instruction, given its late inputs
	function automatic logic [4:0] total_cycles(
		input logic [4:0] cls,
		input logic       t_mode,
		input logic       taken
	);
		logic long_form;
		long_form = 1'b0;
		if (is_branch(cls))
		begin
			long_form = taken;
		end
		else if (is_t_class(cls))
		begin
			long_form = t_mode;
		end
		total_cycles = long_form ? alt_cycles(cls) : base_cycles(cls);
	endfunction

	logic [4:0] total_now;
	logic       ext_seen;
	logic       is_stop_cls;
	logic       is_wait_cls;

	assign total_now   = total_cycles(class_i, q.t_mode, branch_taken_i);
	assign is_stop_cls = (class_i == ics_pkg::CLS_STOP);
	assign is_wait_cls = (class_i == ics_pkg::CLS_WAIT);

	// A pin edge counts only once the second and third stages agree
	always_comb
	begin
		ext_seen = q.ext_level;
		if (q.ext_s2 == q.ext_s3)
		begin
			ext_seen = q.ext_s3;
		end
	end

	always_comb
	begin
		next_q = q;
		next_q.done = 1'b0;
		next_q.ext_s1 = ext_irq_i;
		next_q.ext_s2 = q.ext_s1;
		next_q.ext_s3 = q.ext_s2;
		next_q.ext_level = ext_seen;
		case (q.st)
			ics_pkg::ST_FETCH:
			begin
				// Latch in the second half of the sync cycle
				if (phi_end)
				begin
					next_q.opcode = data_i;
					next_q.t_mode = t_flag_i;
					next_q.cnt = q.cnt + 5'h01;
					next_q.st = ics_pkg::ST_EXEC;
				end
			end
			ics_pkg::ST_EXEC:
			begin
				if (phi_half)
				begin
					next_q.bytes = byte_len(class_i);
				end
				if (phi_end)
				begin
					if (q.cnt >= total_now)
					begin
						next_q.done = 1'b1;
						next_q.cnt = ics_pkg::CYC_FIRST;
						if (is_stop_cls)
						begin
							next_q.st = ics_pkg::ST_STOP;
						end
						else if (is_wait_cls)
						begin
							next_q.st = ics_pkg::ST_WAIT;
						end
						else
						begin
							next_q.st = ics_pkg::ST_FETCH;
						end
					end
					else
					begin
						next_q.cnt = q.cnt + 5'h01;
					end
				end
			end
			ics_pkg::ST_STOP:
			begin
				// Internal events cannot wake the stopped core
				if (phi_end && q.ext_level)
				begin
					next_q.st = ics_pkg::ST_FETCH;
				end
			end
			ics_pkg::ST_WAIT:
			begin
				if (phi_end && (q.ext_level || int_irq_i))
				begin
					next_q.st = ics_pkg::ST_FETCH;
				end
			end
			default:
			begin
				next_q.st = ics_pkg::ST_FETCH;
				next_q.cnt = ics_pkg::CYC_FIRST;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			q <= '0;
			q.st <= ics_pkg::ST_FETCH;
			q.cnt <= ics_pkg::CYC_FIRST;
			q.bytes <= ics_pkg::LEN_ONE;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign phi_o        = phi;
	assign phi_end_o    = phi_end;
	assign sync_o       = (q.st == ics_pkg::ST_FETCH);
	assign opcode_o     = q.opcode;
	assign cycle_o      = q.cnt;
	assign bytes_o      = q.bytes;
	assign instr_done_o = q.done;
	assign stopped_o    = (q.st == ics_pkg::ST_STOP);
	assign waiting_o    = (q.st == ics_pkg::ST_WAIT);

endmodule

// >>> verification/ics_seq_checker.sv
// Port checker for the instruction cycle sequencer
`timescale 1ns/1ps
module ics_seq_checker
(
	input wire logic       sys_clk_i,
	input wire logic       reset_i,
	input wire logic [7:0] data_i,
	input wire logic [4:0] class_i,
	input wire logic       ext_irq_i,
	input wire logic       int_irq_i,
	input wire logic       phi_o,
	input wire logic       phi_end_o,
	input wire logic       sync_o,
	input wire logic [7:0] opcode_o,
	input wire logic [4:0] cycle_o,
	input wire logic       instr_done_o,
	input wire logic       stopped_o,
	input wire logic       waiting_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	wire fetch;
	wire halt_cls;
	assign fetch = phi_end_o && sync_o;
	assign halt_cls = class_i == ics_pkg::CLS_STOP
		|| class_i == ics_pkg::CLS_WAIT;

	a_phi_period: assert property (phi_end_o |=>
		!phi_end_o [*3] ##1 phi_end_o)
		else $error("phi end spacing wrong");
	a_phi_level: assert property ($rose(phi_o) |->
		!phi_end_o ##1 (phi_o && phi_end_o) ##1 !phi_o)
		else $error("phi level wrong");
	a_sync_edge: assert property ($changed(sync_o) |-> $past(phi_end_o))
		else $error("sync changed inside a phi period");
	a_op_latch: assert property (fetch |=> opcode_o == $past(data_i))
		else $error("op code not latched");
	a_op_hold: assert property (!fetch |=> $stable(opcode_o))
		else $error("op code changed outside fetch");
	a_done_sync: assert property (instr_done_o && !halt_cls |->
		sync_o && cycle_o == 5'h01 && $past(phi_end_o))
		else $error("done without fetch sync");
	a_mul_len: assert property (phi_end_o && !sync_o
		&& class_i == ics_pkg::CLS_MUL && cycle_o == 5'h0F |=> sync_o)
		else $error("multiply length wrong");
	a_div_len: assert property (phi_end_o && !sync_o
		&& class_i == ics_pkg::CLS_DIV && cycle_o == 5'h10 |=> sync_o)
		else $error("divide length wrong");
	a_stack_bound: assert property (!(class_i == ics_pkg::CLS_PUSH
		&& cycle_o > 5'h03 || class_i == ics_pkg::CLS_PULL && cycle_o > 5'h04))
		else $error("stack op too long");
	a_stop_hold: assert property (
		(stopped_o && !ext_irq_i) [*6] |=> stopped_o)
		else $error("stop left without external request");
	a_stop_wake: assert property (stopped_o && ext_irq_i
		|-> ##[1:12] !stopped_o)
		else $error("stop not woken");
	a_wait_wake: assert property (waiting_o && (int_irq_i || ext_irq_i)
		|-> ##[1:12] !waiting_o)
		else $error("wait not woken");

	c_div: cover property (instr_done_o && class_i == ics_pkg::CLS_DIV);
	c_stop: cover property ($fell(stopped_o));
	c_wait: cover property ($fell(waiting_o));
endmodule

// >>> verification/ics_mem_model.sv
// Program memory and op code decoder facing the sequencer
`timescale 1ns/1ps
module ics_mem_model
(
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic       sync_i,
	input  wire logic       phi_end_i,
	input  wire logic [7:0] opcode_i,
	output logic      [7:0] data_o,
	output logic      [4:0] class_o
);
	logic [7:0] prog [0:127];
	logic [6:0] pc;
	logic [7:0] last;
	// Bus released outside sync toggles, so stale bytes never match
	assign data_o = sync_i ? prog[pc] : ~last;
	assign class_o = opcode_i[4:0];
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			pc <= 7'h00;
		else if (sync_i && phi_end_i)
			pc <= pc + 7'h01;
		last <= reset_i ? 8'h00 : data_o;
	end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [7:0] op; int cyc; int len;} ics_exp_t;
	localparam logic [4:0] C_STOP = ics_pkg::CLS_STOP;
	localparam logic [4:0] C_WAIT = ics_pkg::CLS_WAIT;
	logic       sys_clk_i;
	logic       reset_i;
	logic       t_flag_i;
	logic       branch_taken_i;
	logic       ext_irq_i;
	logic       int_irq_i;
	logic [7:0] data_i;
	logic [4:0] class_i;
	logic       phi_o;
	logic       phi_end_o;
	logic       sync_o;
	logic [7:0] opcode_o;
	logic [4:0] cycle_o;
	logic [1:0] bytes_o;
	logic       instr_done_o;
	logic       stopped_o;
	logic       waiting_o;
	int         errors;
	int         checked;
	int         cnt;
	int         n;
	ics_exp_t   q[$];
	ics_exp_t   e;
	logic [7:0] op_l [0:127];
	logic       t_l [0:127];
	logic       b_l [0:127];
	int cyc_n [0:30] = '{2,7,2,2,3,4,2,2,4,5,5,4,4,6,15,16,5,7,6,
		2,3,4,4,5,6,6,2,5,8,6,3};
	int cyc_t [0:6] = '{5,6,7,7,8,9,9};
	int len_n [0:30] = '{1,1,1,1,1,1,1,1,2,3,2,3,2,2,2,2,3,2,3,
		2,2,2,3,3,2,2,2,2,2,3,3};

	ics_sequencer u_ics_sequencer (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.data_i(data_i), .class_i(class_i), .t_flag_i(t_flag_i),
		.branch_taken_i(branch_taken_i), .ext_irq_i(ext_irq_i),
		.int_irq_i(int_irq_i), .phi_o(phi_o), .phi_end_o(phi_end_o),
		.sync_o(sync_o), .opcode_o(opcode_o), .cycle_o(cycle_o),
		.bytes_o(bytes_o), .instr_done_o(instr_done_o),
		.stopped_o(stopped_o), .waiting_o(waiting_o));
	ics_mem_model u_ics_mem_model (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.sync_i(sync_o), .phi_end_i(phi_end_o), .opcode_i(opcode_o),
		.data_o(data_i), .class_o(class_i));

	function automatic int exp_cyc(input logic [4:0] c, input logic t,
		input logic b);
		int r;
		r = cyc_n[c];
		if (t && c >= 5'h13 && c <= 5'h19)
			r = cyc_t[c - 5'h13];
		if (b && c == 5'h08)
			r = 6;
		if (b && c == 5'h09)
			r = 7;
		if (b && c == 5'h1A)
			r = 4;
		return r;
	endfunction

	task automatic check(input logic ok, input string what);
		checked++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("Error %0t: %s", $time, what);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic add(input logic [4:0] c, input logic t, input logic b);
		op_l[n] = {3'($urandom), c};
		t_l[n] = t;
		b_l[n] = b;
		u_ics_mem_model.prog[n] = op_l[n];
		n++;
	endtask

	task automatic wait_fetch();
		int k;
		k = 0;
		do
		begin
			@(negedge sys_clk_i);
			k++;
		end
		while (!(sync_o === 1'b1 && phi_end_o === 1'b1) && k < 400);
		if (k >= 400)
		begin
			check(1'b0, "fetch timeout");
			test_done();
		end
	endtask

	// Stop ignores the internal request; it must wait for the pin
	task automatic halt_run(input logic stop, input logic by_ext);
		int k;
		k = 0;
		while ((stop ? stopped_o : waiting_o) !== 1'b1 && k < 100)
		begin
			@(negedge sys_clk_i);
			k++;
		end
		check(k < 100, "no halt");
		int_irq_i = stop | ~by_ext;
		if (stop)
		begin
			repeat (40) @(negedge sys_clk_i);
			check(stopped_o === 1'b1, "stop woke on internal");
		end
		ext_irq_i = by_ext;
		k = 0;
		while ((stop ? stopped_o : waiting_o) !== 1'b0 && k < 100)
		begin
			@(negedge sys_clk_i);
			k++;
		end
		check(k < 100, "no wake");
		int_irq_i = 1'b0;
		ext_irq_i = 1'b0;
	endtask

	initial
	begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// Sampled mid-cycle, where every output has settled
	always @(negedge sys_clk_i)
	begin
		if (reset_i)
			cnt = 0;
		else if (phi_end_o)
			cnt = sync_o ? 1 : cnt + 1;
		if (!reset_i && instr_done_o === 1'b1 && class_i != C_STOP
			&& class_i != C_WAIT)
		begin
			if (q.size() == 0)
				check(1'b0, "done with nothing expected");
			else
			begin
				e = q.pop_front();
				check(cnt == e.cyc, "cycle count");
				check(opcode_o === e.op, "op code");
				check(bytes_o === 2'(e.len), "byte length");
			end
		end
	end

	initial
	begin
		int k;
		logic [4:0] c;
		reset_i = 1'b1;
		t_flag_i = 1'b0;
		branch_taken_i = 1'b0;
		ext_irq_i = 1'b0;
		int_irq_i = 1'b0;
		errors = 0;
		checked = 0;
		n = 0;
		void'($urandom(32'h9F24713C));
		for (k = 0; k < 128; k++)
			u_ics_mem_model.prog[k] = 8'h00;
		for (k = 0; k < 31; k++)
			if (k != 2 && k != 3)
			begin
				add(5'(k), 1'b0, 1'b0);
				add(5'(k), 1'b1, 1'b1);
			end
		for (k = 0; k < 40; k++)
		begin
			c = 5'($urandom_range(30));
			add((c == C_STOP || c == C_WAIT) ? 5'h00 : c,
				1'($urandom), 1'($urandom));
		end
		add(C_STOP, 1'b1, 1'b0);
		add(5'h00, 1'b0, 1'b0);
		add(C_WAIT, 1'b0, 1'b0);
		add(5'h00, 1'b0, 1'b0);
		add(C_WAIT, 1'b1, 1'b0);
		repeat (8) @(negedge sys_clk_i);
		reset_i = 1'b0;
		for (k = 0; k < n; k++)
		begin
			wait_fetch();
			t_flag_i = t_l[k];
			branch_taken_i = b_l[k];
			c = op_l[k][4:0];
			if (c == C_STOP || c == C_WAIT)
				halt_run(c == C_STOP, t_l[k]);
			else
				q.push_back('{op_l[k], exp_cyc(c, t_l[k], b_l[k]), len_n[c]});
		end
		k = 0;
		while (q.size() > 0 && k < 2000)
		begin
			@(negedge sys_clk_i);
			k++;
		end
		check(q.size() == 0, "results missing");
		test_done();
	end
endmodule

bind ics_sequencer ics_seq_checker u_ics_seq_checker (
	.sys_clk_i(sys_clk_i), .reset_i(reset_i), .data_i(data_i),
	.class_i(class_i), .ext_irq_i(ext_irq_i), .int_irq_i(int_irq_i),
	.phi_o(phi_o), .phi_end_o(phi_end_o), .sync_o(sync_o),
	.opcode_o(opcode_o), .cycle_o(cycle_o), .instr_done_o(instr_done_o),
	.stopped_o(stopped_o), .waiting_o(waiting_o));
